// File: logic/rpms_sequencer.v
// reset source combiner and low-power mode sequencer with axi4-lite registers
`timescale 1ns/1ps
`include "rpms_consts.vh"
module rpms_sequencer #(
  parameter [19:0] INIT_CYC  = (`RPMS_INIT_US * `RPMS_CLK_MHZ),
  parameter        SD_SCALE  = `RPMS_CLK_MHZ
) (
  // clock and bus reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // supply monitors and fuses
  input  wire        supply_up,
  input  wire        supply_dip_ok,
  input  wire        dip_fuse,
  input  wire        pin_fuse,
  input  wire [1:0]  start_delay_fuses,
  input  wire        crystal_source,
  // pins and events
  input  wire        shared_reset_pin_in,
  input  wire        ext_int0_n,
  input  wire        external_interrupt_one_n,
  input  wire        general_interrupt_three_n,
  input  wire        watchdog_timeout,
  input  wire        irq_pending,
  // outputs
  output reg         sys_reset,
  output reg         pins_tristate,
  output reg  [15:0] reset_vector,
  output reg         cpu_clk_en,
  output reg         osc_run,
  output reg         flash_power,
  output reg         watchdog_restart,
  output reg         in_system_programming,
  output reg         gpio_pin_in
);
  // ************************************************************
  // sleep states
  // ************************************************************
  localparam [3:0] ST_RUN  = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_DEEP = 4'h4;
  localparam [3:0] ST_WAKE = 4'h8;

  reg  [3:0]  state;
  reg  [19:0] init_cnt;
  reg         init_done;
  reg         por_active;
  reg         dip_active;
  reg  [19:0] sd_cnt;
  reg  [1:0]  pin_lo_cnt;
  reg  [4:0]  pulse_cnt;
  reg  [1:0]  short_cnt;
  reg  [19:0] wake_cnt;
  reg         wake_pin_d;
  reg         wake_rst;
  reg         pwr_idle;
  reg         pwr_deep;
  reg         cold_flag;
  reg         exit_mode;
  reg         wd_ovf;
  reg         sw_flag;
  reg         wd_key1;
  reg         sw_key1;
  reg  [5:0]  wake_cfg;
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  aw_addr;
  reg  [7:0]  w_byte;
  reg         w_lane0;
  reg  [19:0] next_sd_len;

  // ************************************************************
  // start delay table
  // ************************************************************
  always @* begin
    case ({crystal_source, start_delay_fuses})
      3'h0:    next_sd_len = `RPMS_SD_RC0_US * SD_SCALE;
      3'h1:    next_sd_len = `RPMS_SD_RC1_US * SD_SCALE;
      3'h2:    next_sd_len = `RPMS_SD_RC2_US * SD_SCALE;
      3'h3:    next_sd_len = `RPMS_SD_RC3_US * SD_SCALE;
      3'h4:    next_sd_len = `RPMS_SD_XT0_US * SD_SCALE;
      3'h5:    next_sd_len = `RPMS_SD_XT1_US * SD_SCALE;
      3'h6:    next_sd_len = `RPMS_SD_XT2_US * SD_SCALE;
      default: next_sd_len = `RPMS_SD_XT3_US * SD_SCALE;
    endcase
  end

  wire pin_is_reset = pin_fuse | por_active;
  wire pin_low      = ~shared_reset_pin_in;
  wire pin_reset    = pin_is_reset & pin_low & (pin_lo_cnt >= `RPMS_PIN_MIN_CYC);
  wire supply_good  = supply_up & (~dip_fuse | supply_dip_ok);
  wire wake0        = wake_cfg[`RPMS_WK_EXT0_EN] & wake_cfg[`RPMS_WK_EXT0_LVL] & ~ext_int0_n;
  wire wake1        = wake_cfg[`RPMS_WK_EXT1_EN] & wake_cfg[`RPMS_WK_EXT1_LVL] &
                      ~external_interrupt_one_n;
  wire wake3        = ~pin_fuse & wake_cfg[`RPMS_WK_GENERAL_INTERRUPT_THREE_EN] & wake_cfg[`RPMS_WK_GENERAL_INTERRUPT_THREE_LOW] &
                      ~general_interrupt_three_n;
  wire wake_any     = wake0 | wake1 | wake3;
  wire wake_pin     = ~(wake0 | wake1 | wake3);
  wire pulse_rst    = (pulse_cnt != 5'h00) | (short_cnt != 2'h0);
  wire any_reset    = por_active | dip_active | pin_reset | pulse_rst | wake_rst;
  wire wr_go        = aw_held & w_held & ~s_axi_bvalid;

  // ************************************************************
  // supply-up, dip and pin reset sources
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn | !supply_up) begin
      init_cnt   <= 20'h00000;
      init_done  <= 1'b0;
      por_active <= 1'b1;
      dip_active <= 1'b0;
      sd_cnt     <= 20'h00000;
    end else begin
      if (!init_done) begin
        init_cnt <= init_cnt + 20'h00001;
        if (init_cnt + 20'h00001 >= INIT_CYC)
          init_done <= 1'b1;
      end
      if (dip_fuse & !supply_dip_ok & !por_active) begin
        dip_active <= 1'b1;
        sd_cnt     <= 20'h00000;
      end else if ((por_active | dip_active) & init_done & supply_good) begin
        if (sd_cnt + 20'h00001 >= next_sd_len) begin
          if (!(pin_low & por_active)) begin
            por_active <= 1'b0;
            dip_active <= 1'b0;
          end
        end else begin
          sd_cnt <= sd_cnt + 20'h00001;
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_lo_cnt <= 2'h0;
    end else if (pin_low) begin
      if (pin_lo_cnt != `RPMS_PIN_MIN_CYC)
        pin_lo_cnt <= pin_lo_cnt + 2'h1;
    end else begin
      pin_lo_cnt <= 2'h0;
    end
  end

  // ************************************************************
  // sleep sequencer
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn | por_active) begin
      state      <= ST_RUN;
      wake_cnt   <= 20'h00000;
      wake_pin_d <= 1'b1;
      wake_rst   <= 1'b0;
      short_cnt  <= 2'h0;
    end else begin
      wake_pin_d <= wake_pin & (~pin_is_reset | ~pin_low);
      if (short_cnt != 2'h0)
        short_cnt <= short_cnt - 2'h1;
      case (state)
        ST_RUN: begin
          if (pwr_deep)
            state <= ST_DEEP;
          else if (pwr_idle)
            state <= ST_IDLE;
        end
        ST_IDLE: begin
          if (irq_pending | any_reset)
            state <= ST_RUN;
        end
        ST_DEEP: begin
          wake_cnt <= 20'h00000;
          if (pin_is_reset & pin_low) begin
            wake_rst <= 1'b1;
            state    <= ST_WAKE;
          end else if (wake_any) begin
            state <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          if (wake_cnt < next_sd_len)
            wake_cnt <= wake_cnt + 20'h00001;
          if (wake_rst) begin
            if (wake_cnt >= next_sd_len & !pin_low) begin
              wake_rst <= 1'b0;
              state    <= ST_RUN;
            end else if (wake_cnt >= next_sd_len & pin_low) begin
              wake_rst <= 1'b1;
            end else if (!pin_low & wake_cnt + 20'h00001 >= next_sd_len) begin
              wake_rst  <= 1'b0;
              short_cnt <= `RPMS_SHORT_CYC;
              state     <= ST_RUN;
            end
          end else if (!exit_mode) begin
            if (wake_cnt >= next_sd_len)
              state <= ST_RUN;
          end else if (wake_pin & !wake_pin_d) begin
            state <= ST_RUN;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // ************************************************************
  // axi4-lite write path and key sequences
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RPMS_AXI_OKAY;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
      pwr_idle      <= 1'b0;
      pwr_deep      <= 1'b0;
      cold_flag     <= 1'b1;
      exit_mode     <= 1'b0;
      wd_ovf        <= 1'b0;
      sw_flag       <= 1'b0;
      wd_key1       <= 1'b0;
      sw_key1       <= 1'b0;
      wake_cfg      <= 6'h00;
      pulse_cnt     <= 5'h00;
      watchdog_restart <= 1'b0;
    end else begin
      s_axi_awready    <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready     <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      watchdog_restart <= 1'b0;
      if (s_axi_awready & s_axi_awvalid) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wready & s_axi_wvalid) begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (pulse_cnt != 5'h00)
        pulse_cnt <= pulse_cnt - 5'h01;
      if (state == ST_IDLE & (irq_pending | any_reset))
        pwr_idle <= 1'b0;
      if (state == ST_WAKE & (wake_cnt >= next_sd_len | exit_mode))
        pwr_deep <= 1'b0;
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RPMS_AXI_OKAY;
        case (aw_addr)
          `RPMS_OFF_PWR: if (w_lane0) begin
            pwr_idle  <= w_byte[`RPMS_PWR_IDLE];
            pwr_deep  <= w_byte[`RPMS_PWR_DEEP];
            cold_flag <= w_byte[`RPMS_PWR_COLD];
            exit_mode <= w_byte[`RPMS_PWR_EXITMODE];
          end
          `RPMS_OFF_WDCTL: if (w_lane0) begin
            wd_ovf  <= w_byte[`RPMS_WD_OVF];
            sw_flag <= w_byte[`RPMS_WD_SWR];
          end
          `RPMS_OFF_WDRESTART: if (w_lane0) begin
            wd_key1 <= (w_byte == `RPMS_WD_KEY1);
            if (wd_key1 & w_byte == `RPMS_WD_KEY2)
              watchdog_restart <= 1'b1;
          end
          `RPMS_OFF_SWRESET: if (w_lane0) begin
            sw_key1 <= (w_byte == `RPMS_SW_KEY1);
            if (sw_key1 & w_byte == `RPMS_SW_KEY2) begin
              pulse_cnt <= `RPMS_PULSE_CYC;
              sw_flag   <= 1'b1;
            end
          end
          `RPMS_OFF_WAKECFG: if (w_lane0)
            wake_cfg <= w_byte[5:0];
          `RPMS_OFF_STATUS: s_axi_bresp <= `RPMS_AXI_OKAY;
          default: s_axi_bresp <= `RPMS_AXI_SLVERR;
        endcase
      end
      if (watchdog_timeout) begin
        pulse_cnt <= `RPMS_PULSE_CYC;
        wd_ovf    <= 1'b1;
      end
      if (por_active)
        cold_flag <= 1'b1;
      if (any_reset) begin
        pwr_idle <= 1'b0;
        pwr_deep <= 1'b0;
      end
    end
  end

  // ************************************************************
  // axi4-lite read path
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RPMS_AXI_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arready & s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RPMS_AXI_OKAY;
        case (s_axi_araddr)
          `RPMS_OFF_PWR:       s_axi_rdata <= {26'h0000000, exit_mode, cold_flag,
                                              2'h0, pwr_deep, pwr_idle};
          `RPMS_OFF_WDCTL:     s_axi_rdata <= {30'h00000000, sw_flag, wd_ovf};
          `RPMS_OFF_WDRESTART: s_axi_rdata <= 32'h00000000;
          `RPMS_OFF_SWRESET:   s_axi_rdata <= 32'h00000000;
          `RPMS_OFF_WAKECFG:   s_axi_rdata <= {26'h0000000, wake_cfg};
          `RPMS_OFF_STATUS:    s_axi_rdata <= {24'h000000, state, por_active,
                                              dip_active, pin_reset, any_reset};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RPMS_AXI_SLVERR;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset     <= 1'b1;
      pins_tristate <= 1'b1;
      reset_vector  <= `RPMS_RESET_VECTOR;
      cpu_clk_en    <= 1'b0;
      osc_run       <= 1'b1;
      flash_power   <= 1'b1;
      in_system_programming <= 1'b0;
      gpio_pin_in   <= 1'b1;
    end else begin
      sys_reset     <= any_reset;
      pins_tristate <= any_reset;
      reset_vector  <= `RPMS_RESET_VECTOR;
      cpu_clk_en    <= ~any_reset & (state == ST_RUN);
      osc_run       <= (state != ST_DEEP);
      flash_power   <= (state != ST_DEEP);
      in_system_programming <= pin_is_reset & pin_low;
      gpio_pin_in   <= pin_is_reset ? 1'b1 : shared_reset_pin_in;
    end
  end
endmodule // rpms_sequencer

// File: logic/rpms_consts.vh
// constants for the reset and power mode sequencer
`ifndef RPMS_CONSTS_VH
`define RPMS_CONSTS_VH
// ************************************************************
// register byte offsets
// ************************************************************
`define RPMS_OFF_PWR      8'h00
`define RPMS_OFF_WDCTL    8'h04
`define RPMS_OFF_WDRESTART 8'h08
`define RPMS_OFF_SWRESET  8'h0C
`define RPMS_OFF_WAKECFG  8'h10
`define RPMS_OFF_STATUS   8'h14
// ************************************************************
// power control and watchdog control register fields
// ************************************************************
`define RPMS_PWR_IDLE     0
`define RPMS_PWR_DEEP     1
`define RPMS_PWR_COLD     4
`define RPMS_PWR_EXITMODE 5
`define RPMS_WD_OVF       0
`define RPMS_WD_SWR       1
// ************************************************************
// wake configuration fields
// ************************************************************
`define RPMS_WK_EXT0_EN   0
`define RPMS_WK_EXT0_LVL  1
`define RPMS_WK_EXT1_EN   2
`define RPMS_WK_EXT1_LVL  3
`define RPMS_WK_GENERAL_INTERRUPT_THREE_EN   4
`define RPMS_WK_GENERAL_INTERRUPT_THREE_LOW  5
// ************************************************************
// key bytes and reset vector
// ************************************************************
`define RPMS_WD_KEY1      8'h1E
`define RPMS_WD_KEY2      8'hE1
`define RPMS_SW_KEY1      8'h5A
`define RPMS_SW_KEY2      8'hA5
`define RPMS_RESET_VECTOR 16'h0000
// ************************************************************
// timing, clock 20 MHz, and axi responses
// ************************************************************
`define RPMS_CLK_MHZ      20
`define RPMS_INIT_US      92
`define RPMS_PULSE_CYC    5'h10
`define RPMS_PIN_MIN_CYC  2'h2
`define RPMS_SHORT_CYC    2'h2
`define RPMS_SD_RC0_US    16
`define RPMS_SD_RC1_US    512
`define RPMS_SD_RC2_US    1024
`define RPMS_SD_RC3_US    4096
`define RPMS_SD_XT0_US    1024
`define RPMS_SD_XT1_US    2048
`define RPMS_SD_XT2_US    4096
`define RPMS_SD_XT3_US    16384
`define RPMS_AXI_OKAY     2'h0
`define RPMS_AXI_SLVERR   2'h2
`endif

// File: verification/rpms_monitor.sv
// assertions on the reset and power mode sequencer ports
`timescale 1ns/1ps
module rpms_monitor (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // supply, fuses, pins, events
  input wire logic        supply_up,
  input wire logic        supply_dip_ok,
  input wire logic        dip_fuse,
  input wire logic        pin_fuse,
  input wire logic        shared_reset_pin_in,
  input wire logic        watchdog_timeout,
  // outputs
  input wire logic        sys_reset,
  input wire logic        pins_tristate,
  input wire logic [15:0] reset_vector,
  input wire logic        cpu_clk_en,
  input wire logic        osc_run,
  input wire logic        watchdog_restart
);
  // ************
  // properties
  // ************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence pin_held;
    pin_fuse && cpu_clk_en && !shared_reset_pin_in ##1 !shared_reset_pin_in [*2];
  endsequence
  sequence long_pulse;
    sys_reset [*8];
  endsequence
  a_tristate_mirror: assert property (sys_reset && $past(sys_reset) |-> pins_tristate)
    else $error("pins driven during reset");
  a_vector_zero: assert property (sys_reset |-> reset_vector == 16'h0000)
    else $error("reset vector not zero");
  a_supply_drop: assert property (!supply_up |-> ##[0:2] sys_reset)
    else $error("no reset on supply drop");
  a_dip_drop: assert property (dip_fuse && !supply_dip_ok |-> ##[0:2] sys_reset)
    else $error("no reset on supply dip");
  a_pin_reset: assert property (pin_held |-> ##[0:2] sys_reset)
    else $error("pin held low without reset");
  a_wd_pulse: assert property ($rose(watchdog_timeout) |-> ##[1:3] long_pulse)
    else $error("watchdog reset too short");
  a_cpu_gated: assert property ($rose(sys_reset) |=> !cpu_clk_en [*2])
    else $error("cpu clock runs in reset");
  a_osc_needed: assert property (!osc_run |-> !cpu_clk_en)
    else $error("cpu clock without oscillator");
  a_restart_pulse: assert property (watchdog_restart |=> !watchdog_restart)
    else $error("restart pulse too long");
endmodule // rpms_monitor

bind rpms_sequencer rpms_monitor u_rpms_monitor (
  .aclk, .aresetn, .supply_up, .supply_dip_ok, .dip_fuse, .pin_fuse,
  .shared_reset_pin_in, .watchdog_timeout, .sys_reset, .pins_tristate,
  .reset_vector, .cpu_clk_en, .osc_run, .watchdog_restart
);

// File: verification/rpms_partner.sv
// model of the supply monitors, reset pin and wake pins
`timescale 1ns/1ps
module rpms_partner (
  // clock
  input wire logic aclk,
  // supply monitors
  output logic     supply_up = 1'h0,
  output logic     supply_dip_ok = 1'h0,
  // pins, pulled up when released
  output logic     shared_reset_pin_in = 1'h1,
  output logic     ext_int0_n = 1'h1,
  output logic     external_interrupt_one_n = 1'h1,
  output logic     general_interrupt_three_n = 1'h1
);
  // ************
  // drivers
  // ************
  // levels change just after the caller's clock edge
  task supply(input logic up, input logic dip);
    supply_up <= up;
    supply_dip_ok <= dip;
  endtask
  // pin low for n cycles, then back to its pull-up
  task pin_low(input integer n);
    shared_reset_pin_in <= 1'h0;
    repeat (n) @(posedge aclk);
    shared_reset_pin_in <= 1'h1;
  endtask
  // one wake line low for n cycles; long holds let the clock settle
  task wake(input integer k, input integer n);
    {general_interrupt_three_n, external_interrupt_one_n, ext_int0_n} <= ~(3'h1 << k);
    repeat (n) @(posedge aclk);
    {general_interrupt_three_n, external_interrupt_one_n, ext_int0_n} <= 3'h7;
  endtask
endmodule // rpms_partner

// File: verification/tb_rpms_sequencer.sv
// self-checking bench for the reset and power mode sequencer
`timescale 1ns/1ps
module tb_rpms_sequencer;
  // ************
  // signals
  // ************
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, start_delay_fuses = 2'h0;
  logic        dip_fuse = 1'h0, pin_fuse = 1'h0, crystal_source = 1'h0;
  logic        watchdog_timeout = 1'h0, irq_pending = 1'h0, rs_seen = 1'h0;
  logic        supply_up, supply_dip_ok, shared_reset_pin_in, ext_int0_n;
  logic        external_interrupt_one_n, general_interrupt_three_n;
  logic        sys_reset, pins_tristate, cpu_clk_en, osc_run, flash_power;
  logic        watchdog_restart, in_system_programming, gpio_pin_in;
  logic [15:0] reset_vector;
  integer      n_errors = 0, check_count = 0, cyc = 0, run = 0, last = 0, fell = 0, n, mark;
  int          sd [8] = '{16, 512, 1024, 4096, 1024, 2048, 4096, 16384};
  always #25 aclk = ~aclk;
  rpms_sequencer #(.INIT_CYC(20'h8), .SD_SCALE(1)) u_rpms_sequencer (.*);
  rpms_partner u_rpms_partner (.*);
  // reset pulse length, restart pulse and run limit
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (watchdog_restart === 1'h1) rs_seen <= 1'h1;
    if (sys_reset === 1'h1) run <= run + 1;
    else begin
      if (run != 0) last <= run;
      if (run != 0) fell <= cyc;
      run <= 0;
    end
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      summarize;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask
  // wait for reset (cpu=0) or cpu clock (cpu=1) to reach lvl
  task wait_on(input bit cpu, input logic lvl, input integer max);
    n = 0;
    while (((cpu ? cpu_clk_en : sys_reset) !== lvl) && n < max) begin
      @(posedge aclk);
      n = n + 1;
    end
    check(n < max, 1, "wait");
    @(posedge aclk);
  endtask
  task summarize;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ************
  // tests
  // ************
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    u_rpms_partner.supply(1'h1, 1'h1);
    fork
      u_rpms_partner.pin_low(40);
      begin
        repeat (38) @(posedge aclk);
        check(sys_reset, 1, "pin extends");
        check(in_system_programming, 1, "isp");
        check(pins_tristate, 1, "tristate");
      end
    join
    wait_on(0, 1'h0, 8);
    check(reset_vector, 0, "vector");
    rd(8'h00);
    check(rd_v[4], 1, "cold flag");
    wr(8'h00, 32'h0);
    u_rpms_partner.supply(1'h0, 1'h1);
    repeat (5) @(posedge aclk);
    u_rpms_partner.supply(1'h1, 1'h1);
    wait_on(0, 1'h0, 40);
    check(last >= 26 && last <= 34, 1, "supply cycle");
    rd(8'h00);
    check(rd_v[4], 1, "cold again");
    wr(8'h00, 32'h0);
    wr(8'h0C, 32'h5A);
    wr(8'h0C, 32'h5B);
    wr(8'h0C, 32'hA5);
    repeat (3) @(posedge aclk);
    check(sys_reset, 0, "broken key");
    wr(8'h0C, 32'h5A);
    wr(8'h0C, 32'hA5);
    wait_on(0, 1'h1, 8);
    wait_on(0, 1'h0, 24);
    check(last, 16, "sw pulse");
    rd(8'h04);
    check(rd_v[1], 1, "sw flag");
    rd(8'h00);
    check(rd_v[4], 0, "warm reset");
    wr(8'h04, 32'h0);
    watchdog_timeout <= 1'h1;
    @(posedge aclk);
    watchdog_timeout <= 1'h0;
    wait_on(0, 1'h1, 4);
    wait_on(0, 1'h0, 24);
    check(last, 16, "wd pulse");
    rd(8'h04);
    check(rd_v[0], 1, "wd flag");
    wr(8'h08, 32'h1E);
    check(rs_seen, 0, "half key");
    wr(8'h08, 32'hE1);
    repeat (2) @(posedge aclk);
    check(rs_seen, 1, "restart");
    s_axi_wstrb <= 4'h0;
    wr(8'h00, 32'h1);
    s_axi_wstrb <= 4'hF;
    rd(8'h00);
    check(rd_v[0], 0, "strobe off idle");
    pin_fuse <= 1'h1;
    u_rpms_partner.pin_low(5);
    check(sys_reset, 1, "pin reset");
    wait_on(0, 1'h0, 40);
    pin_fuse <= 1'h0;
    fork
      u_rpms_partner.pin_low(6);
      begin
        repeat (4) @(posedge aclk);
        check(gpio_pin_in, 0, "gpio in");
        check(sys_reset, 0, "fuse off");
      end
    join
    wr(8'h00, 32'h1);
    repeat (2) @(posedge aclk);
    check(cpu_clk_en, 0, "idle");
    irq_pending <= 1'h1;
    wait_on(1, 1'h1, 8);
    irq_pending <= 1'h0;
    for (int k = 0; k < 3; k++) begin
      wr(8'h10, 32'h3 << (2 * k));
      wr(8'h00, 32'h2);
      repeat (2) @(posedge aclk);
      check({osc_run, flash_power}, 0, "deep");
      u_rpms_partner.wake(k, 2);
      wait_on(1, 1'h1, 40);
      check(n >= 12, 1, "timed wake");
    end
    wr(8'h10, 32'hC);
    wr(8'h00, 32'h22);
    fork
      u_rpms_partner.wake(1, 60);
      begin
        repeat (40) @(posedge aclk);
        check({osc_run, cpu_clk_en}, 2, "held wake");
      end
    join
    wait_on(1, 1'h1, 8);
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h2);
    u_rpms_partner.wake(0, 4);
    repeat (30) @(posedge aclk);
    check(osc_run, 0, "edge no wake");
    mark = cyc;
    pin_fuse <= 1'h1;
    u_rpms_partner.pin_low(3);
    wait_on(1, 1'h1, 60);
    check(fell > mark && last >= 2, 1, "reset wake");
    dip_fuse <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      {crystal_source, start_delay_fuses} <= 3'(i);
      @(posedge aclk);
      u_rpms_partner.supply(1'h1, 1'h0);
      repeat (3) @(posedge aclk);
      u_rpms_partner.supply(1'h1, 1'h1);
      wait_on(0, 1'h0, 16400);
      check(last > sd[i] && last <= sd[i] + 7, 1, "start delay");
    end
    {crystal_source, start_delay_fuses} <= 3'h0;
    u_rpms_partner.supply(1'h0, 1'h0);
    @(posedge aclk);
    u_rpms_partner.supply(1'h1, 1'h0);
    repeat (30) @(posedge aclk);
    check(sys_reset, 1, "dip wait");
    u_rpms_partner.supply(1'h1, 1'h1);
    wait_on(0, 1'h0, 40);
    check(n >= 15, 1, "dip delay");
    rd(8'h20);
    check(rsp, 2'h2, "unmapped resp");
    check(rd_v, 0, "unmapped data");
    summarize;
  end
endmodule // tb_rpms_sequencer
